// ---- hw/iogs_pkg.sv ----
// Shared constants and carrier types for the IMU output group serializer.
// Assumes all users reference items as iogs_pkg::name, with no import.
package iogs_pkg;

  // Selection mask layout
  localparam int              MASK_W   = 16;       // Width of selection mask
  localparam int              NFIELD   = 11;       // Fields that can be selected
  localparam logic [15:0]     USED_BITS = 16'h07ff; // Bits 0..10 select fields
  localparam logic [3:0]      F_STATUS = 4'h0;     // Sensor state word bit
  localparam logic [3:0]      F_ANG    = 4'h6;     // Angle increment bit
  localparam logic [3:0]      F_VEL    = 4'h7;     // Velocity increment bit

  // Field byte lengths
  localparam logic [4:0]      LEN_STATUS = 5'h02;  // Unsigned 16-bit word
  localparam logic [4:0]      LEN_SCALAR = 5'h04;  // One float
  localparam logic [4:0]      LEN_VEC    = 5'h0c;  // Three floats
  localparam logic [4:0]      LEN_ANGLE  = 5'h10;  // Interval plus three floats

  // Word positions in the snapshot store
  localparam int              W_RAWF = 0;          // Raw field vector
  localparam int              W_RAWA = 3;          // Raw specific force
  localparam int              W_RAWR = 6;          // Raw rate vector
  localparam int              W_TEMP = 9;          // Temperature
  localparam int              W_PRES = 10;         // Barometric value
  localparam int              W_ANG  = 11;         // Interval, then angle axes
  localparam int              W_VEL  = 15;         // Velocity axes
  localparam int              W_CORF = 18;         // Corrected field vector
  localparam int              W_CORA = 21;         // Corrected specific force
  localparam int              W_CORR = 24;         // Corrected rate vector
  localparam int              NWORD  = 27;         // Snapshot words

  // Increment integration
  localparam int              SAMPLE_HZ   = 800;   // Nominal inertial sample rate
  localparam int              FRAC_BITS   = 16;    // Accumulators are Q16.16
  localparam logic [31:0]     SAMPLE_DT_Q = 32'((64'h1 << FRAC_BITS) / SAMPLE_HZ);
  localparam int              FLOAT_BIAS  = 127;   // Single-precision exponent bias

  // Payload buffer
  localparam int              FIFO_W = 8;          // Byte wide
  localparam int              FIFO_D = 16;         // Sixteen entries

  typedef logic [2:0][31:0] iogs_vec_t;            // Axes 2..0, axis 0 in low word

  typedef struct packed {
    iogs_vec_t   raw_field_vector;
    iogs_vec_t   raw_specific_force;
    iogs_vec_t   raw_rate_vector;
    logic [31:0] temperature;
    logic [31:0] barometric;
    iogs_vec_t   corrected_field;
    iogs_vec_t   corrected_force;
    iogs_vec_t   corrected_rate_vector;
  } iogs_sensor_t;

  typedef struct packed {
    logic [31:0] interval;
    iogs_vec_t   angle_increment;
    iogs_vec_t   velocity_increment;
  } iogs_incr_t;

  typedef enum logic [1:0] { ST_IDLE, ST_SNAP, ST_GRAB, ST_EMIT } iogs_state_t;

  // Byte length of a field by its selection bit
  function automatic logic [4:0] field_len(input logic [3:0] f);
    case (f)
      4'h0:       return LEN_STATUS;
      4'h4, 4'h5: return LEN_SCALAR;
      4'h6:       return LEN_ANGLE;
      4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'ha: return LEN_VEC;
      default:    return 5'h00;
    endcase
  endfunction

  // First snapshot word of a field by its selection bit
  function automatic logic [4:0] field_base(input logic [3:0] f);
    case (f)
      4'h1:    return 5'(W_RAWF);
      4'h2:    return 5'(W_RAWA);
      4'h3:    return 5'(W_RAWR);
      4'h4:    return 5'(W_TEMP);
      4'h5:    return 5'(W_PRES);
      4'h6:    return 5'(W_ANG);
      4'h7:    return 5'(W_VEL);
      4'h8:    return 5'(W_CORF);
      4'h9:    return 5'(W_CORA);
      4'ha:    return 5'(W_CORR);
      default: return 5'h00;
    endcase
  endfunction

endpackage

// ---- hw/iogs_fifo.sv ----
// Payload byte FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module iogs_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];      // Storage
  logic [AW-1:0] wr_ptr;      // Next write slot
  logic [AW-1:0] rd_ptr;      // Next read slot
  logic [AW:0]   count;       // Entries held
  logic          do_wr;       // Write this cycle
  logic          do_rd;       // Read this cycle

  assign in_ready  = count != (AW+1)'(D);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else if (do_wr && !do_rd) begin
      count <= count + 1'b1;
    end else if (do_rd && !do_wr) begin
      count <= count - 1'b1;
    end
  end
endmodule

// ---- hw/iogs_accum.sv ----
// Angle and velocity increment accumulators with clear-on-readout.
// Assumes per-sample increments in Q16.16 on the same clock.
`timescale 1ns/1ns
module iogs_accum (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Per-sample increments
  input  wire logic              sample,
  input  wire iogs_pkg::iogs_vec_t ang_in,
  input  wire iogs_pkg::iogs_vec_t vel_in,
  // Readout and clear
  input  wire logic              clr_ang,
  input  wire logic              clr_vel,
  output iogs_pkg::iogs_incr_t   held
);
  logic [6:0][31:0] add_in;   // 0 interval, 1..3 angle, 4..6 velocity
  logic [6:0]       clr_v;    // Clear per accumulator
  logic [31:0]      acc [7];  // Running sums
  logic [31:0]      flt [7];  // Floats latched at readout

  assign add_in = {vel_in, ang_in, iogs_pkg::SAMPLE_DT_Q};
  assign clr_v  = {{3{clr_vel}}, {4{clr_ang}}};
  assign held   = {flt[0], flt[3], flt[2], flt[1], flt[6], flt[5], flt[4]};

  // Signed Q16.16 to single precision, truncating the mantissa
  function automatic logic [31:0] to_float(input logic [31:0] q);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [4:0]  p;
    mag = q[31] ? 32'(-q) : q;
    p = '0;
    for (int k = 0; k < 32; k++) begin
      if (mag[k]) begin
        p = 5'(k);
      end
    end
    norm = mag << (5'd31 - p);
    if (mag == '0) begin
      return '0;
    end
    return {q[31], 8'(iogs_pkg::FLOAT_BIAS + int'(p) - iogs_pkg::FRAC_BITS), norm[30:8]};
  endfunction

  // Integrate once per sample; a sample in the clear cycle starts the new sum
  always_ff @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (reset) begin
        acc[i] <= '0;
      end else if (clr_v[i]) begin
        acc[i] <= sample ? add_in[i] : '0;
      end else if (sample) begin
        acc[i] <= acc[i] + add_in[i];
      end
    end
  end

  // Latch the value being read out
  always_ff @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (reset) begin
        flt[i] <= '0;
      end else if (clr_v[i]) begin
        flt[i] <= to_float(acc[i]);
      end
    end
  end

  property p_integrate;
    @(posedge clk) disable iff (reset)
    sample && !clr_ang |=> acc[0] == $past(acc[0]) + iogs_pkg::SAMPLE_DT_Q;
  endproperty
  a_integrate: assert property (p_integrate) else $error("interval not integrated");

  property p_ang_clear;
    @(posedge clk) disable iff (reset)
    clr_ang |=> acc[1] == ($past(sample) ? $past(add_in[1]) : '0) &&
      acc[0] == ($past(sample) ? iogs_pkg::SAMPLE_DT_Q : '0);
  endproperty
  a_ang_clear: assert property (p_ang_clear) else $error("angle sum not cleared");

  property p_vel_clear;
    @(posedge clk) disable iff (reset)
    clr_vel |=> acc[4] == ($past(sample) ? $past(add_in[4]) : '0);
  endproperty
  a_vel_clear: assert property (p_vel_clear) else $error("velocity sum not cleared");
endmodule

// ---- hw/iogs_serializer.sv ----
// IMU output group serializer: builds the selected payload bytes.
// Assumes sensor values, strobes and polls come from logic on clk.
// Notes on behaviour
// - Mask bits 0..10 select the eleven fields
// - State word: two bytes, always zero
// - Raw field vector: three floats, twelve bytes
// - Raw specific force: three floats, twelve bytes
// - Raw rate vector: three floats, ascending axes
// - Temperature: one float, four bytes
// - Barometric value: one absolute-pressure float
// - Angle increment: interval then three axes
// - Accumulate increments and interval per sample
// - Clear angle sum on poll or send
// - Clear velocity sum on poll or send
// - Velocity increment: three floats, twelve bytes
// - Corrected field vector: three floats
// - Corrected specific force: three floats
// - Corrected rate vector: three floats
`timescale 1ns/1ns
module iogs_serializer (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Configuration
  input  wire logic [15:0]           group_mask,
  // Sensor values and per-sample increments
  input  wire iogs_pkg::iogs_sensor_t sensors,
  input  wire logic                  sample_strobe,
  input  wire iogs_pkg::iogs_vec_t   angle_in,
  input  wire iogs_pkg::iogs_vec_t   velocity_in,
  // Host polls of the increments
  input  wire logic                  poll_angle,
  input  wire logic                  poll_velocity,
  output iogs_pkg::iogs_incr_t       polled_incr,
  // Frame control and status
  input  wire logic                  frame_req,
  output logic                       frame_busy,
  output logic                       frame_done,
  // Payload byte stream
  output logic                       pay_valid,
  output logic [7:0]                 pay_data,
  input  wire logic                  pay_ready
);
  // Frame timing: request taken in idle, sensors frozen the next cycle,
  // increments one cycle later, then one cycle per byte or skipped field
  iogs_pkg::iogs_state_t state;      // Frame sequencer state
  iogs_pkg::iogs_state_t next_state; // Its next value
  logic [15:0] mask_q;               // Mask latched for this frame
  logic [31:0] snap [iogs_pkg::NWORD]; // Field words frozen for the frame
  logic [3:0]  fld;                  // Field being emitted
  logic [4:0]  bix;                  // Byte within that field
  logic        sel;                  // Current field is selected
  logic        last_b;               // Current byte ends the field
  logic        push;                 // Byte enters the FIFO
  logic [31:0] cur_word;             // Word holding the current byte
  logic [7:0]  push_byte;            // Byte entering the FIFO
  logic        clr_ang;              // Angle readout this cycle
  logic        clr_vel;              // Velocity readout this cycle
  logic        fifo_in_ready;        // FIFO has room
  logic        fifo_out_valid;       // FIFO holds a byte
  logic        fifo_out_ready;       // Output stage can take a byte
  logic [7:0]  fifo_out_data;        // Byte at the FIFO head

  // Field decode for the current position
  assign sel      = mask_q[fld];
  assign last_b   = bix == iogs_pkg::field_len(fld) - 5'h01;
  assign cur_word = snap[iogs_pkg::field_base(fld) + 5'(bix[4:2])];
  assign push     = state == iogs_pkg::ST_EMIT && fld < 4'(iogs_pkg::NFIELD) && sel && fifo_in_ready;

  // State word is always zero; floats go low byte first
  always_comb begin
    if (fld == iogs_pkg::F_STATUS) begin
      push_byte = 8'h00;
    end else begin
      push_byte = cur_word[8*bix[1:0] +: 8];
    end
  end

  // Readouts clear the accumulators: host poll or a frame carrying the field
  // A send clears in the snapshot cycle; the frame carries the old sum
  assign clr_ang = poll_angle || (state == iogs_pkg::ST_SNAP && mask_q[iogs_pkg::F_ANG]);
  assign clr_vel = poll_velocity || (state == iogs_pkg::ST_SNAP && mask_q[iogs_pkg::F_VEL]);

  // Increment sums; a readout latches the floats and clears the sums
  iogs_accum u_accum (
    .clk     (clk),
    .reset   (reset),
    .sample  (sample_strobe),
    .ang_in  (angle_in),
    .vel_in  (velocity_in),
    .clr_ang (clr_ang),
    .clr_vel (clr_vel),
    .held    (polled_incr)
  );

  // Payload buffer absorbs host stalls; the walk waits while it is full
  iogs_fifo #(
    .W (iogs_pkg::FIFO_W),
    .D (iogs_pkg::FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_byte),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Sequencer: request, snapshot, collect increments, emit
  always_comb begin
    next_state = state;
    unique case (state)
      iogs_pkg::ST_IDLE: begin
        if (frame_req) begin
          next_state = iogs_pkg::ST_SNAP;
        end
      end
      iogs_pkg::ST_SNAP: begin
        next_state = iogs_pkg::ST_GRAB;
      end
      iogs_pkg::ST_GRAB: begin
        next_state = iogs_pkg::ST_EMIT;
      end
      // Leave once the walk has passed the last field
      iogs_pkg::ST_EMIT: begin
        if (fld == 4'(iogs_pkg::NFIELD)) begin
          next_state = iogs_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= iogs_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Mask capture; spare bits select nothing
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= '0;
    end else if (state == iogs_pkg::ST_IDLE && frame_req) begin
      mask_q <= group_mask & iogs_pkg::USED_BITS;
    end
  end

  // Freeze sensor words at frame start, increments one cycle later
  always_ff @(posedge clk) begin
    if (state == iogs_pkg::ST_SNAP) begin
      for (int a = 0; a < 3; a++) begin
        snap[iogs_pkg::W_RAWF + a] <= sensors.raw_field_vector[a];
        snap[iogs_pkg::W_RAWA + a] <= sensors.raw_specific_force[a];
        snap[iogs_pkg::W_RAWR + a] <= sensors.raw_rate_vector[a];
        snap[iogs_pkg::W_CORF + a] <= sensors.corrected_field[a];
        snap[iogs_pkg::W_CORA + a] <= sensors.corrected_force[a];
        snap[iogs_pkg::W_CORR + a] <= sensors.corrected_rate_vector[a];
      end
      snap[iogs_pkg::W_TEMP] <= sensors.temperature;
      snap[iogs_pkg::W_PRES] <= sensors.barometric;
    end else if (state == iogs_pkg::ST_GRAB) begin
      snap[iogs_pkg::W_ANG] <= polled_incr.interval;
      for (int a = 0; a < 3; a++) begin
        snap[iogs_pkg::W_ANG + 1 + a] <= polled_incr.angle_increment[a];
        snap[iogs_pkg::W_VEL + a]     <= polled_incr.velocity_increment[a];
      end
    end
  end

  // Field and byte walk, skipping unselected fields
  always_ff @(posedge clk) begin
    if (reset || state == iogs_pkg::ST_SNAP) begin
      fld <= '0;
      bix <= '0;
    end else if (state == iogs_pkg::ST_EMIT && fld < 4'(iogs_pkg::NFIELD)) begin
      if (!sel) begin
        fld <= fld + 4'h1;
      end else if (push && last_b) begin
        fld <= fld + 4'h1;
        bix <= '0;
      end else if (push) begin
        bix <= bix + 5'h01;
      end
    end
  end

  // Frame status flags
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_busy <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      frame_busy <= next_state != iogs_pkg::ST_IDLE;
      frame_done <= state == iogs_pkg::ST_EMIT && fld == 4'(iogs_pkg::NFIELD);
    end
  end

  // Registered output stage; stalls the FIFO when the host holds off
  assign fifo_out_ready = !pay_valid || pay_ready;

  // Output register loads whenever it is empty or being taken
  always_ff @(posedge clk) begin
    if (reset) begin
      pay_valid <= 1'b0;
      pay_data  <= 8'h00;
    end else if (fifo_out_ready) begin
      pay_valid <= fifo_out_valid;
      pay_data  <= fifo_out_data;
    end
  end

  // Checks on the field walk, the frame flags and the output stream
  // Only selected fields reach the buffer
  property p_sel_only;
    @(posedge clk) disable iff (reset)
    push |-> mask_q[fld] && fld < 4'(iogs_pkg::NFIELD);
  endproperty
  a_sel_only: assert property (p_sel_only) else $error("unselected field emitted");

  // Spare mask bits never take effect
  property p_spare;
    @(posedge clk) disable iff (reset)
    state != iogs_pkg::ST_IDLE |-> mask_q[15:11] == 5'h00;
  endproperty
  a_spare: assert property (p_spare) else $error("spare mask bit honoured");

  // State word bytes are zero and only two of them
  property p_status_zero;
    @(posedge clk) disable iff (reset)
    push && fld == iogs_pkg::F_STATUS |-> push_byte == 8'h00 && bix < iogs_pkg::LEN_STATUS;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("state word not zero");

  // A field ends after exactly its own byte count
  property p_len;
    @(posedge clk) disable iff (reset)
    push && last_b |=> fld == $past(fld) + 4'h1 && bix == 5'h00;
  endproperty
  a_len: assert property (p_len) else $error("field length wrong");

  // Field index moves by at most one per cycle
  property p_order;
    @(posedge clk) disable iff (reset)
    state == iogs_pkg::ST_EMIT && $past(state) == iogs_pkg::ST_EMIT |->
      fld == $past(fld) || fld == $past(fld) + 4'h1;
  endproperty
  a_order: assert property (p_order) else $error("field order broken");

  // Byte one of a float follows byte zero
  property p_lsb_first;
    @(posedge clk) disable iff (reset)
    push && fld != iogs_pkg::F_STATUS && bix[1:0] == 2'h0 |=>
      push_byte == $past(cur_word[15:8]) || !push;
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("float byte order wrong");

  // Unselected field costs one cycle and no byte
  property p_skip;
    @(posedge clk) disable iff (reset)
    state == iogs_pkg::ST_EMIT && fld < 4'(iogs_pkg::NFIELD) && !sel |=> fld == $past(fld) + 4'h1;
  endproperty
  a_skip: assert property (p_skip) else $error("unselected field not skipped");

  // Request in idle raises busy and latches the used mask bits
  property p_take;
    @(posedge clk) disable iff (reset)
    state == iogs_pkg::ST_IDLE && frame_req |=>
      frame_busy && mask_q == ($past(group_mask) & iogs_pkg::USED_BITS);
  endproperty
  a_take: assert property (p_take) else $error("request not taken");

  // Done is a lone pulse with busy already low
  property p_done;
    @(posedge clk) disable iff (reset)
    frame_done |-> !frame_busy ##1 !frame_done;
  endproperty
  a_done: assert property (p_done) else $error("frame flags wrong");

  // Output byte holds while the host stalls
  property p_hold;
    @(posedge clk) disable iff (reset)
    pay_valid && !pay_ready |=> pay_valid && $stable(pay_data);
  endproperty
  a_hold: assert property (p_hold) else $error("payload byte dropped");

  // Main scenarios: full group, empty group, stall, increments, host hold
  c_full: cover property (@(posedge clk) disable iff (reset)
    frame_done && mask_q == iogs_pkg::USED_BITS);
  c_empty: cover property (@(posedge clk) disable iff (reset)
    frame_done && mask_q == 16'h0000);
  c_stall: cover property (@(posedge clk) disable iff (reset)
    state == iogs_pkg::ST_EMIT && sel && !fifo_in_ready);
  c_incr: cover property (@(posedge clk) disable iff (reset)
    frame_done && mask_q[iogs_pkg::F_ANG] && mask_q[iogs_pkg::F_VEL]);
  c_hold: cover property (@(posedge clk) disable iff (reset)
    pay_valid && !pay_ready);
endmodule

// ---- verification/iogs_host_model.sv ----
// Host-side sink model for the serializer payload stream.
// Assumes one clock shared with the serializer and a synchronous reset.
`timescale 1ns/1ns
module iogs_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Mode: stall two cycles out of four
  input  wire logic       slow,
  // Payload stream
  input  wire logic       pay_valid,
  input  wire logic [7:0] pay_data,
  output logic            pay_ready
);
  logic [1:0] phase;   // Stall pattern counter
  logic [7:0] rx_q[$]; // Accepted bytes, oldest first

  // Stall pattern advances just after each edge
  always_ff @(posedge clk) begin
    phase <= reset ? 2'h0 : phase + 2'h1;
  end

  // Ready low in reset; in slow mode only on half the cycles
  assign pay_ready = ~reset & (~slow | phase[1]);

  // Take one byte per handshake and queue it behind those taken before
  always @(posedge clk) begin
    if (!reset && pay_valid && pay_ready) begin
      rx_q.push_back(pay_data);
    end
  end
endmodule

// ---- verification/iogs_serializer_tb_top.sv ----
// Self-checking bench for the IMU output group serializer.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ns
module iogs_serializer_tb_top;
  logic                   clk           = 1'b0;  // 100 MHz clock
  logic                   reset         = 1'b1;  // Synchronous reset
  logic [15:0]            group_mask    = 16'h0000;
  iogs_pkg::iogs_sensor_t sensors       = '0;
  logic                   sample_strobe = 1'b0;
  iogs_pkg::iogs_vec_t    angle_in      = {32'h0003_0000, 32'h0002_0000, 32'h0001_0000};
  iogs_pkg::iogs_vec_t    velocity_in   = {32'h0006_0000, 32'h0005_0000, 32'h0004_0000};
  logic                   poll_angle    = 1'b0;
  logic                   poll_velocity = 1'b0;
  logic                   frame_req     = 1'b0;
  logic                   slow          = 1'b0;  // Host stall mode
  iogs_pkg::iogs_incr_t   polled_incr;
  logic                   frame_busy;
  logic                   frame_done;
  logic                   pay_valid;
  logic                   pay_ready;
  logic [7:0]             pay_data;
  int                     bad_count     = 0;
  int                     total_checks  = 0;
  int                     cycles        = 0;     // Timeout counter
  logic [31:0]            exp_dt        = '0;    // Expected interval float
  iogs_pkg::iogs_vec_t    exp_ang       = '0;    // Expected angle floats
  iogs_pkg::iogs_vec_t    exp_vel       = '0;    // Expected velocity floats
  logic [7:0]             exp_q[$];              // Expected payload bytes

  // Design under test
  iogs_serializer i_dut (
    .clk(clk), .reset(reset), .group_mask(group_mask), .sensors(sensors),
    .sample_strobe(sample_strobe), .angle_in(angle_in), .velocity_in(velocity_in),
    .poll_angle(poll_angle), .poll_velocity(poll_velocity), .polled_incr(polled_incr),
    .frame_req(frame_req), .frame_busy(frame_busy), .frame_done(frame_done),
    .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready)
  );

  // Host side of the payload stream
  iogs_host_model i_host (
    .clk(clk), .reset(reset), .slow(slow),
    .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready)
  );

  // Clock
  always #5 clk = ~clk;

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // Compare one value
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Queue n bytes of a word, low byte first
  task automatic put_bytes(input logic [31:0] w, input int n);
    for (int b = 0; b < n; b++) exp_q.push_back(w[8*b +: 8]);
  endtask

  // Queue three axes in ascending order
  task automatic put_vec(input iogs_pkg::iogs_vec_t v);
    for (int a = 0; a < 3; a++) put_bytes(v[a], 4);
  endtask

  // Expected payload for a mask, fields in ascending bit order
  task automatic build_exp(input logic [15:0] m);
    exp_q = {};
    if (m[0]) put_bytes(32'h0000_0000, 2);
    if (m[1]) put_vec(sensors.raw_field_vector);
    if (m[2]) put_vec(sensors.raw_specific_force);
    if (m[3]) put_vec(sensors.raw_rate_vector);
    if (m[4]) put_bytes(sensors.temperature, 4);
    if (m[5]) put_bytes(sensors.barometric, 4);
    if (m[6]) put_bytes(exp_dt, 4);
    if (m[6]) put_vec(exp_ang);
    if (m[7]) put_vec(exp_vel);
    if (m[8]) put_vec(sensors.corrected_field);
    if (m[9]) put_vec(sensors.corrected_force);
    if (m[10]) put_vec(sensors.corrected_rate_vector);
  endtask

  // Request one frame, wait for it to drain, compare every byte
  task automatic run_frame(input logic [15:0] m);
    int n;
    build_exp(m);
    i_host.rx_q = {};
    @(negedge clk);
    group_mask = m;
    frame_req = 1'b1;
    @(negedge clk);
    frame_req = 1'b0;
    check(96'(frame_busy), 96'h1);
    n = 0;
    while (frame_done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(96'(frame_done), 96'h1);
    while (i_host.rx_q.size() < exp_q.size() && n < 1200) begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    check(96'(frame_busy), 96'h0);
    check(96'(i_host.rx_q.size()), 96'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < i_host.rx_q.size(); i++) begin
      check(96'(i_host.rx_q[i]), 96'(exp_q[i]));
    end
  endtask

  // Give k inertial samples
  task automatic samples(input int k);
    repeat (k) begin
      @(negedge clk);
      sample_strobe = 1'b1;
      @(negedge clk);
      sample_strobe = 1'b0;
    end
  endtask

  // Poll angle (ang high) or velocity (ang low) for one cycle
  task automatic poll(input logic ang);
    @(negedge clk);
    poll_angle = ang;
    poll_velocity = ~ang;
    @(negedge clk);
    poll_angle = 1'b0;
    poll_velocity = 1'b0;
    @(negedge clk);
  endtask

  // Main sequence
  initial begin
    for (int w = 0; w < 22; w++) sensors[32*w +: 32] = {8'(w), 8'h5a, 8'hc3, 8'(8'h80 + w)};
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(96'({pay_valid, frame_busy, frame_done}), 96'h0);
    check(96'(|polled_incr), 96'h0);
    reset = 1'b0;
    $display("test reset done");
    // Each selection bit alone, then an empty mask
    for (int b = 0; b < 11; b++) run_frame(16'h0001 << b);
    run_frame(16'h0000);
    $display("test single fields done");
    // Every field with a stalling host, buffer fills
    slow = 1'b1;
    run_frame(16'h07ff);
    $display("test full group done");
    // Increments sent, then cleared by the send
    samples(2);
    exp_dt = 32'h3b22_0000;
    exp_ang = {32'h40c0_0000, 32'h4080_0000, 32'h4000_0000};
    exp_vel = {32'h4140_0000, 32'h4120_0000, 32'h4100_0000};
    run_frame(16'h00c0);
    exp_dt = '0;
    exp_ang = '0;
    exp_vel = '0;
    run_frame(16'h00c0);
    $display("test increments sent done");
    // Polls read out and clear each sum on its own
    slow = 1'b0;
    samples(3);
    poll(1'b1);
    check(96'(polled_incr.interval), 96'h3b73_0000);
    check(polled_incr.angle_increment, {32'h4110_0000, 32'h40c0_0000, 32'h4040_0000});
    poll(1'b0);
    check(polled_incr.velocity_increment, {32'h4190_0000, 32'h4170_0000, 32'h4140_0000});
    poll(1'b1);
    check(polled_incr.angle_increment, 96'h0);
    run_frame(16'h00c0);
    $display("test polls done");
    wrap_up();
  end
endmodule
